// ==== pcom_regs.vh ====
// Purpose: Constants for the port pin output combiner.
// Assumes: Included by the combiner and its synchroniser.
// Notes: Select codes pick which configuration register a write loads.
`ifndef PCOM_REGS_VH
`define PCOM_REGS_VH

// Configuration write select codes.
`define PCOM_SEL_W 4
`define PCOM_SEL_LATCH 4'h0
`define PCOM_SEL_DIR 4'h1
`define PCOM_SEL_OD 4'h2
`define PCOM_SEL_ANALOG 4'h3
`define PCOM_SEL_SER_OE 4'h4
`define PCOM_SEL_SER_LVL 4'h5
`define PCOM_SEL_SER_CHEN 4'h6
`define PCOM_SEL_TMR_OE 4'h7
`define PCOM_SEL_TMR_LVL 4'h8
`define PCOM_SEL_I2C_EN 4'h9
`define PCOM_SEL_CLK_EN 4'hA
`define PCOM_SEL_REDIR 4'hB

// Per-bit reset values.
`define PCOM_LATCH_RST 1'b0
`define PCOM_DIR_RST 1'b1
`define PCOM_OD_RST 1'b0
`define PCOM_ANALOG_RST 1'b0
`define PCOM_SER_OE_RST 1'b0
`define PCOM_SER_LVL_RST 1'b1
`define PCOM_SER_CHEN_RST 1'b0
`define PCOM_TMR_OE_RST 1'b0
`define PCOM_TMR_LVL_RST 1'b0
`define PCOM_I2C_EN_RST 1'b0
`define PCOM_CLK_EN_RST 1'b0
`define PCOM_REDIR_RST 1'b0

// Field meanings.
`define PCOM_DIR_INPUT 1'b1
`define PCOM_OD_OPEN 1'b1
`define PCOM_SER_ABSENT 1'b1
`define PCOM_NS_ABSENT 1'b0
`define PCOM_OD_ABSENT 1'b0

`endif

// ==== pcom_sync3.v ====
// Purpose: Three-stage synchroniser for one pin input.
// Assumes: The pin is asynchronous to clk.
// Notes: The output changes only when stages two and three agree.
`timescale 1ns/10ps
`include "pcom_regs.vh"

module pcom_sync3 (
  // Clock and reset.
  input wire clk,
  input wire resetn,
  // Raw pin level and its filtered copy.
  input wire async_in,
  output reg sync_out
);

  reg stage1; // First stage, read only by stage two.
  reg stage2; // Second stage.
  reg stage3; // Third stage.

  // Shift the pin through three flops and accept a level once it is
  // seen twice in a row, so one metastable sample cannot flip the output.
  always @(posedge clk) begin
    if (!resetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        sync_out <= stage3;
      end
    end
  end

endmodule // pcom_sync3

// ==== pcom_combiner.v ====
// Purpose: Output combiner for a group of shared digital port pins.
// Assumes: Software loads configuration through cfg_we and cfg_sel.
// Notes: Pin output is (latch AND serial) OR non-serial alternates.
// Operation
// - Reset leaves every pin input, buffer off.
// - Open-drain select bit one gives open-drain.
// - Open-drain high output leaves pin undriven.
// - Port latch ANDed with serial output.
// - AND result ORed with non-serial alternates.
// - No open-drain select means push-pull.
// - Missing serial function feeds one to AND.
// - Missing non-serial function feeds zero to OR.
// - Reset puts alternate controls in idle state.
// - Redirection moves timer output to another pin.
`timescale 1ns/10ps
`include "pcom_regs.vh"

module pcom_combiner #(
  parameter N = 8, // Number of pins in the group.
  parameter [N-1:0] HAS_OD = {N{1'b1}}, // Pins with open-drain select.
  parameter [N-1:0] HAS_SER = {N{1'b1}}, // Pins with a serial output.
  parameter [N-1:0] HAS_TMR = {N{1'b1}}, // Pins with a timer output.
  parameter [N-1:0] HAS_I2C = {N{1'b0}}, // Pins with an I2C output.
  parameter [N-1:0] HAS_CLK = {N{1'b0}}, // Pins with a clock output.
  parameter REDIR_SHIFT = 4 // Pin offset a redirected timer moves by.
) (
  // Clock and reset.
  input wire clk,
  input wire resetn,
  // Configuration write port.
  input wire cfg_we,
  input wire [`PCOM_SEL_W-1:0] cfg_sel,
  input wire [N-1:0] cfg_wdata,
  // Live outputs of the alternate functions, one bit per pin.
  input wire [N-1:0] serial_live,
  input wire [N-1:0] timer_live,
  input wire [N-1:0] i2c_live,
  input wire [N-1:0] clock_buzzer_live,
  // Pin pads.
  input wire [N-1:0] pin_i,
  output reg [N-1:0] pin_o,
  output reg [N-1:0] pin_oe,
  // Port read value and configuration readback.
  output reg [N-1:0] port_read,
  output reg [N-1:0] pin_direction_reg,
  output reg [N-1:0] open_drain_select_reg
);

  reg [N-1:0] out_latch; // Port output latch.
  reg [N-1:0] analog_digital_select; // One marks analog use.
  reg [N-1:0] serial_out_enable_reg; // Serial output enable per pin.
  reg [N-1:0] serial_out_level_reg; // Serial idle level per pin.
  reg [N-1:0] channel_enable_status_reg; // Serial channel running.
  reg [N-1:0] timer_out_enable_reg; // Timer output enable.
  reg [N-1:0] timer_out_level_reg; // Timer idle level.
  reg [N-1:0] i2c_operation_enable; // I2C unit running.
  reg [N-1:0] clock_out_enable_bit; // Clock/buzzer output enable.
  reg [N-1:0] peripheral_redirect_reg; // Timer redirection per channel.
  wire [N-1:0] pin_sync; // Synchronised pin levels.
  reg [N-1:0] ser_src; // Serial input to the AND stage.
  reg [N-1:0] tmr_pin; // Timer value after redirection.
  reg [N-1:0] ns_src; // Non-serial input to the OR stage.
  reg [N-1:0] od_ctl; // Effective open-drain control.
  reg [N-1:0] value; // Combined pin value.
  reg [N-1:0] next_pin_o; // Next pad output level.
  reg [N-1:0] next_pin_oe; // Next pad output enable.
  reg [N-1:0] next_port_read; // Next port read value.
  integer i; // Loop index of the pad process only.
  integer j; // Pin that the current timer channel lands on when redirected.
  integer r; // Loop index of the redirection process only.
  integer c; // Loop index of the combining process only.

  // Each pad passes a three-stage synchroniser before it is read.
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : gen_sync
      pcom_sync3 u_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in(pin_i[g]),
        .sync_out(pin_sync[g])
      );
    end
  endgenerate

  // Configuration registers. Reset leaves pins as inputs and every
  // alternate control in its unused idle state.
  always @(posedge clk) begin
    if (!resetn) begin
      out_latch <= {N{`PCOM_LATCH_RST}};
      pin_direction_reg <= {N{`PCOM_DIR_RST}};
      open_drain_select_reg <= {N{`PCOM_OD_RST}};
      analog_digital_select <= {N{`PCOM_ANALOG_RST}};
      serial_out_enable_reg <= {N{`PCOM_SER_OE_RST}};
      serial_out_level_reg <= {N{`PCOM_SER_LVL_RST}};
      channel_enable_status_reg <= {N{`PCOM_SER_CHEN_RST}};
      timer_out_enable_reg <= {N{`PCOM_TMR_OE_RST}};
      timer_out_level_reg <= {N{`PCOM_TMR_LVL_RST}};
      i2c_operation_enable <= {N{`PCOM_I2C_EN_RST}};
      clock_out_enable_bit <= {N{`PCOM_CLK_EN_RST}};
      peripheral_redirect_reg <= {N{`PCOM_REDIR_RST}};
    end else if (cfg_we) begin
      case (cfg_sel)
        `PCOM_SEL_LATCH: begin
          out_latch <= cfg_wdata;
        end
        `PCOM_SEL_DIR: begin
          pin_direction_reg <= cfg_wdata;
        end
        `PCOM_SEL_OD: begin
          // Bits of pins without an open-drain stage stay cleared.
          open_drain_select_reg <= cfg_wdata & HAS_OD;
        end
        `PCOM_SEL_ANALOG: begin
          analog_digital_select <= cfg_wdata;
        end
        `PCOM_SEL_SER_OE: begin
          serial_out_enable_reg <= cfg_wdata;
        end
        `PCOM_SEL_SER_LVL: begin
          serial_out_level_reg <= cfg_wdata;
        end
        `PCOM_SEL_SER_CHEN: begin
          channel_enable_status_reg <= cfg_wdata;
        end
        `PCOM_SEL_TMR_OE: begin
          timer_out_enable_reg <= cfg_wdata;
        end
        `PCOM_SEL_TMR_LVL: begin
          timer_out_level_reg <= cfg_wdata;
        end
        `PCOM_SEL_I2C_EN: begin
          i2c_operation_enable <= cfg_wdata;
        end
        `PCOM_SEL_CLK_EN: begin
          clock_out_enable_bit <= cfg_wdata;
        end
        `PCOM_SEL_REDIR: begin
          peripheral_redirect_reg <= cfg_wdata;
        end
        default: begin
          // Unknown selects are ignored so a stray write is harmless.
          out_latch <= out_latch;
        end
      endcase
    end
  end

  // Timer redirection: channel i leaves pin i and appears on pin
  // (i + REDIR_SHIFT) mod N, freeing pin i for other use.
  // Each process owns its own loop index, so no variable has two drivers.
  always @* begin
    tmr_pin = {N{1'b0}};
    j = 0;
    for (r = 0; r < N; r = r + 1) begin
      j = (r + REDIR_SHIFT) % N;
      if (peripheral_redirect_reg[r]) begin
        tmr_pin[j] = tmr_pin[j] | (timer_out_enable_reg[r] ?
          timer_live[r] : timer_out_level_reg[r]);
      end else begin
        tmr_pin[r] = tmr_pin[r] | (timer_out_enable_reg[r] ?
          timer_live[r] : timer_out_level_reg[r]);
      end
    end
  end

  // Source selection and the AND/OR combining stage. A disabled serial
  // output shows its level bit; disabled I2C and clock outputs show
  // low. Absent functions take the neutral value of their gate.
  always @*  begin
    // Whole-vector defaults first, so no bit can hold a latch.
    ser_src = {N{1'b0}};
    ns_src = {N{1'b0}};
    od_ctl = {N{1'b0}};
    for (c = 0; c < N; c = c + 1) begin
      if (HAS_SER[c]) begin
        ser_src[c] = (channel_enable_status_reg[c] &
          serial_out_enable_reg[c]) ? serial_live[c] :
          serial_out_level_reg[c];
      end else begin
        ser_src[c] = `PCOM_SER_ABSENT;
      end
      ns_src[c] = `PCOM_NS_ABSENT;
      if (HAS_TMR[c]) begin
        ns_src[c] = ns_src[c] | tmr_pin[c];
      end
      if (HAS_I2C[c]) begin
        ns_src[c] = ns_src[c] | (i2c_operation_enable[c] & i2c_live[c]);
      end
      if (HAS_CLK[c]) begin
        ns_src[c] = ns_src[c] |
          (clock_out_enable_bit[c] & clock_buzzer_live[c]);
      end
      od_ctl[c] = HAS_OD[c] ? open_drain_select_reg[c] :
        `PCOM_OD_ABSENT;
    end
    value = (out_latch & ser_src) | ns_src;
  end

  // Pad drive and read value. An open-drain pin only pulls low and
  // releases the line for a high value; an analog pin is never driven.
  // The read value follows the latch in output mode and the pin in
  // input mode; analog pins read as zero.
  always @* begin
    next_pin_o = {N{1'b0}};
    next_pin_oe = {N{1'b0}};
    next_port_read = {N{1'b0}};
    for (i = 0; i < N; i = i + 1) begin
      if (od_ctl[i] == `PCOM_OD_OPEN) begin
        next_pin_o[i] = 1'b0;
        next_pin_oe[i] = (pin_direction_reg[i] != `PCOM_DIR_INPUT) &
          ~analog_digital_select[i] & ~value[i];
      end else begin
        next_pin_o[i] = value[i];
        next_pin_oe[i] = (pin_direction_reg[i] != `PCOM_DIR_INPUT) &
          ~analog_digital_select[i];
      end
      if (analog_digital_select[i]) begin
        next_port_read[i] = 1'b0;
      end else if (pin_direction_reg[i] == `PCOM_DIR_INPUT) begin
        next_port_read[i] = pin_sync[i];
      end else begin
        next_port_read[i] = out_latch[i];
      end
    end
  end

  // Registered pad outputs. The one-cycle delay keeps glitches from
  // the combining gates off the pins.
  always @(posedge clk) begin
    if (!resetn) begin
      pin_o <= {N{1'b0}};
      pin_oe <= {N{1'b0}};
      port_read <= {N{1'b0}};
    end else begin
      pin_o <= next_pin_o;
      pin_oe <= next_pin_oe;
      port_read <= next_port_read;
    end
  end

endmodule // pcom_combiner

// ==== pcom_combiner_checker.sv ====
// Purpose: Concurrent checks on the port pin output combiner ports.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Bound into every combiner instance after the module.
`timescale 1ns/10ps
`include "pcom_regs.vh"

module pcom_combiner_checker #(
  parameter N = 8, // Number of pins in the group.
  parameter [N-1:0] HAS_OD = {N{1'b1}} // Pins with open-drain select.
) (
  // Clock and reset.
  input logic clk,
  input logic resetn,
  // Configuration write port.
  input logic cfg_we,
  input logic [`PCOM_SEL_W-1:0] cfg_sel,
  input logic [N-1:0] cfg_wdata,
  // Pad outputs and readback.
  input logic [N-1:0] pin_o,
  input logic [N-1:0] pin_oe,
  input logic [N-1:0] port_read,
  input logic [N-1:0] pin_direction_reg,
  input logic [N-1:0] open_drain_select_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // A write that loads the open-drain register.
  sequence s_od_wr;
    cfg_we && cfg_sel == `PCOM_SEL_OD;
  endsequence

  // A write that loads the direction register.
  sequence s_dir_wr;
    cfg_we && cfg_sel == `PCOM_SEL_DIR;
  endsequence

  // Reset values are checked at the first edge after release.
  AST_RESET_QUIET: assert property ($rose(resetn) |->
    pin_oe == '0 && pin_o == '0 && port_read == '0)
    else $error("pad active after reset");
  AST_RESET_CFG: assert property ($rose(resetn) |->
    pin_direction_reg == '1 && open_drain_select_reg == '0)
    else $error("configuration not idle after reset");
  // The buffer follows the direction held one edge earlier.
  AST_OE_INPUT: assert property (
    (pin_oe & $past(pin_direction_reg)) == '0)
    else $error("input pin driven");
  // An open-drain pin never drives a high level.
  AST_OD_LOW: assert property (
    (pin_o & $past(open_drain_select_reg)) == '0)
    else $error("open-drain pin drives high");
  AST_OD_ABSENT: assert property (
    (open_drain_select_reg & ~HAS_OD) == '0)
    else $error("open-drain set on pin without select");
  AST_OD_WRITE: assert property (s_od_wr |=>
    open_drain_select_reg == ($past(cfg_wdata) & HAS_OD))
    else $error("open-drain write not taken");
  AST_DIR_WRITE: assert property (s_dir_wr |=>
    pin_direction_reg == $past(cfg_wdata))
    else $error("direction write not taken");
  // Two edges after a direction write, input pins are released.
  AST_DIR_TO_OE: assert property (s_dir_wr ##2 1'b1 |->
    (pin_oe & $past(cfg_wdata, 2)) == '0)
    else $error("buffer on for pin set to input");
endmodule // pcom_combiner_checker

bind pcom_combiner pcom_combiner_checker #(.N(N), .HAS_OD(HAS_OD)) u_chk (
  .clk(clk),
  .resetn(resetn),
  .cfg_we(cfg_we),
  .cfg_sel(cfg_sel),
  .cfg_wdata(cfg_wdata),
  .pin_o(pin_o),
  .pin_oe(pin_oe),
  .port_read(port_read),
  .pin_direction_reg(pin_direction_reg),
  .open_drain_select_reg(open_drain_select_reg)
);

// ==== pcom_target.sv ====
// Purpose: External target device on pulled-up pins.
// Assumes: The target only ever pulls a line low, never high.
// Notes: An undriven line reads high through the external resistor.
`timescale 1ns/10ps

module pcom_target #(
  parameter N = 8 // Number of pins in the group.
) (
  // Pad outputs of the combiner.
  input wire [N-1:0] pin_o,
  input wire [N-1:0] pin_oe,
  // Pull-down request of the target, one bit per line.
  input wire [N-1:0] pull_low,
  // Resolved line level fed back to the pad inputs.
  output wire [N-1:0] pin_i
);
  // A released line floats to the pull-up, so it is never left unknown.
  assign pin_i = ~pull_low & ((pin_oe & pin_o) | ~pin_oe);
endmodule // pcom_target

// ==== port_pin_output_combiner_test.sv ====
// Purpose: Directed test of the port pin output combiner.
// Assumes: Eight pins, a pulled-up target, inputs driven at rising edges.
// Notes: Masks leave pin 7 push-pull, pin 6 without serial, pin 5 no timer.
`timescale 1ns/10ps
`include "pcom_regs.vh"

module port_pin_output_combiner_test;
  reg clk = 1'b0; // System clock, 100 MHz.
  reg resetn = 1'b0; // Reset is asserted at time zero.
  reg cfg_we = 1'b0;
  reg [3:0] cfg_sel = 4'h0;
  reg [7:0] cfg_wdata = 8'h00;
  reg [7:0] ser = 8'h00, tmr = 8'h00, i2c = 8'h00, cbz = 8'h00;
  reg [7:0] tgt_low = 8'h00; // Target pulls these lines low.
  wire [7:0] pin_i, pin_o, pin_oe, port_read, dir_q, od_q;
  int miscompares = 0;
  int samples_checked = 0;

  // Free-running clock.
  initial begin
    forever #5 clk = ~clk;
  end

  // The width stays at its default of eight pins.
  pcom_combiner #(.HAS_OD(8'h7F), .HAS_SER(8'hBF),
    .HAS_TMR(8'hDF), .HAS_I2C(8'h01), .HAS_CLK(8'h02)) i_dut (
    .clk(clk), .resetn(resetn), .cfg_we(cfg_we), .cfg_sel(cfg_sel),
    .cfg_wdata(cfg_wdata), .serial_live(ser), .timer_live(tmr),
    .i2c_live(i2c), .clock_buzzer_live(cbz), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe), .port_read(port_read),
    .pin_direction_reg(dir_q), .open_drain_select_reg(od_q));

  pcom_target i_tgt (.pin_o(pin_o), .pin_oe(pin_oe),
    .pull_low(tgt_low), .pin_i(pin_i));

  // One configuration write; the strobe stands for exactly one edge.
  task wr(input [3:0] sel, input [7:0] data);
    @(posedge clk);
    cfg_we <= 1'b1;
    cfg_sel <= sel;
    cfg_wdata <= data;
    @(posedge clk);
    cfg_we <= 1'b0;
  endtask

  // Live alternate outputs and the target's pull-downs.
  task live(input [7:0] s, t, i, c, p);
    @(posedge clk);
    ser <= s;
    tmr <= t;
    i2c <= i;
    cbz <= c;
    tgt_low <= p;
  endtask

  // Waits past the register and output flop, then off the edge.
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task cmp(input [7:0] got, input [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task summarize;
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Cuts a hang short; the whole run needs well under 1000 cycles.
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    summarize;
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    cmp(pin_oe, 8'h00);
    cmp(dir_q, 8'hFF);
    cmp(od_q, 8'h00);
    // Push-pull port output with idle serial levels high.
    wr(`PCOM_SEL_LATCH, 8'hFF);
    wr(`PCOM_SEL_DIR, 8'h00);
    settle;
    cmp(pin_o, 8'hFF);
    cmp(pin_oe, 8'hFF);
    // Latch low lets the timer through the OR stage.
    wr(`PCOM_SEL_LATCH, 8'h00);
    wr(`PCOM_SEL_TMR_OE, 8'hFF);
    live(8'h00, 8'h2F, 8'h00, 8'h00, 8'h00);
    settle;
    cmp(pin_o, 8'h0F);
    wr(`PCOM_SEL_REDIR, 8'h01);
    live(8'h00, 8'h01, 8'h00, 8'h00, 8'h00);
    settle;
    cmp(pin_o, 8'h10);
    // I2C and clock outputs reach only their own pins.
    wr(`PCOM_SEL_TMR_OE, 8'h00);
    wr(`PCOM_SEL_I2C_EN, 8'hFF);
    wr(`PCOM_SEL_CLK_EN, 8'hFF);
    live(8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00);
    settle;
    cmp(pin_o, 8'h03);
    wr(`PCOM_SEL_I2C_EN, 8'h00);
    wr(`PCOM_SEL_CLK_EN, 8'h00);
    settle;
    cmp(pin_o, 8'h00);
    // A disabled timer shows its level bit; channel 0 still lands on 4.
    wr(`PCOM_SEL_TMR_LVL, 8'h05);
    settle;
    cmp(pin_o, 8'h14);
    wr(`PCOM_SEL_TMR_LVL, 8'h00);
    settle;
    cmp(pin_o, 8'h00);
    // Second reset, then the open-drain serial bring-up order.
    @(posedge clk);
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    wr(`PCOM_SEL_LATCH, 8'hFF);
    wr(`PCOM_SEL_OD, 8'hFF);
    wr(`PCOM_SEL_SER_CHEN, 8'hFF);
    wr(`PCOM_SEL_SER_OE, 8'hFF);
    live(8'hAA, 8'h00, 8'h00, 8'h00, 8'h00);
    settle;
    cmp(od_q, 8'h7F);
    cmp(pin_oe, 8'h00);
    wr(`PCOM_SEL_DIR, 8'h00);
    settle;
    cmp(pin_o, 8'h80);
    cmp(pin_oe, 8'h95);
    live(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    settle;
    cmp(pin_oe, 8'hBF);
    // A stopped channel shows its level bit at the AND stage.
    wr(`PCOM_SEL_SER_CHEN, 8'h00);
    wr(`PCOM_SEL_SER_LVL, 8'h0F);
    settle;
    cmp(pin_oe, 8'hB0);
    cmp(pin_o, 8'h00);
    // Input reads through the synchroniser; analog pin reads zero.
    wr(`PCOM_SEL_DIR, 8'hFF);
    live(8'h00, 8'h00, 8'h00, 8'h00, 8'hF0);
    wr(`PCOM_SEL_ANALOG, 8'h01);
    repeat (6) @(posedge clk);
    settle;
    cmp(port_read, 8'h0E);
    cmp(pin_oe, 8'h00);
    summarize;
  end
endmodule // port_pin_output_combiner_test
